/* src/fhc_host.sv */
`timescale 1ns/1ps
module fhc_host
  import fhc_pkg::*;
#(
  parameter int WAKE_CYCLES = WAKE_CYC
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic req_valid,
  output logic req_ready,
  input wire fhc_req_t req,
  input wire logic powerdown_req,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_data,
  output logic busy_level,
  output logic done_pulse,
  output fhc_pins_t pins,
  output logic [DATA_W-1:0] dq_out,
  output logic [1:0] dq_oe,
  input wire logic [DATA_W-1:0] dq_in,
  input wire logic automation_status_out
);
  // Wake count must fit the shared cycle counter
  if (WAKE_CYCLES < 1 || WAKE_CYCLES >= (1 << CNT_W))
  begin : g_wake_range
    $error("WAKE_CYCLES out of range");
  end

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [DATA_W-1:0] dq_s;
  logic sts_s;
  logic sts_prev_q;

  // Status resets to its pulled-up idle level: no false edge after reset
  fhc_sync #(.W(DATA_W+1), .RST_VAL({1'b1, {DATA_W{1'b0}}})) fhc_sync_inst
  (
    .mclk(mclk),
    .rst_n(rst_n),
    .d({automation_status_out, dq_in}),
    .q({sts_s, dq_s})
  );

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  fhc_state_t state_q;
  logic [CNT_W-1:0] cnt_q;
  fhc_req_t cur_q;

  function automatic logic [ADDR_W-1:0] pin_addr(fhc_req_t r);
    logic [ADDR_W-1:0] a;
    a = r.addr;
    if (r.wide)
      a[0] = 1'b0;
    return a;
  endfunction : pin_addr

  assign req_ready = (state_q == FHC_IDLE) && !powerdown_req;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= FHC_RESET;
      cnt_q <= '0;
    end
    else if (powerdown_req)
    begin
      state_q <= FHC_RESET;
      cnt_q <= '0;
    end
    else
    begin
      case (state_q)
        FHC_RESET:
        begin
          state_q <= FHC_WAKE;
          cnt_q <= CNT_W'(WAKE_CYCLES - 1);
        end
        FHC_WAKE:
        begin
          if (cnt_q == '0)
            state_q <= FHC_IDLE;
          else
            cnt_q <= cnt_q - 1'b1;
        end
        FHC_IDLE:
        begin
          if (req_valid)
          begin
            state_q <= req.write ? FHC_WSETUP : FHC_RSTROBE;
            cnt_q <= req.write ? CNT_W'(SETUP_CYC - 1)
                               : CNT_W'(READ_CYC - 1);
          end
        end
        FHC_WSETUP:
        begin
          if (cnt_q == '0)
          begin
            state_q <= FHC_WSTROBE;
            cnt_q <= CNT_W'(STROBE_CYC - 1);
          end
          else
            cnt_q <= cnt_q - 1'b1;
        end
        FHC_WSTROBE, FHC_RSTROBE:
        begin
          if (cnt_q == '0)
          begin
            state_q <= FHC_HOLD;
            cnt_q <= CNT_W'(SETUP_CYC - 1);
          end
          else
            cnt_q <= cnt_q - 1'b1;
        end
        FHC_HOLD:
        begin
          if (cnt_q == '0)
            state_q <= FHC_IDLE;
          else
            cnt_q <= cnt_q - 1'b1;
        end
        default:
          state_q <= FHC_RESET;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      cur_q <= '0;
    else if (req_valid && req_ready)
      cur_q <= req;
  end

  // ------------------------------------------------------------
  // Pin drive
  // ------------------------------------------------------------
  logic in_cycle;
  assign in_cycle = (state_q == FHC_WSETUP) || (state_q == FHC_WSTROBE) ||
                    (state_q == FHC_RSTROBE) || (state_q == FHC_HOLD);

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pins <= '{cs_n: CS_IDLE, oe_n: 1'b1, we_n: 1'b1, width_sel: 1'b0,
                reset_powerdown_n: 1'b0, addr: '0};
      dq_out <= '0;
      dq_oe <= 2'h0;
    end
    else
    begin
      pins.reset_powerdown_n <= !powerdown_req && (state_q != FHC_RESET);
      pins.cs_n <= in_cycle ? CS_ACTIVE : CS_IDLE;
      pins.we_n <= !(state_q == FHC_WSTROBE);
      pins.oe_n <= !(state_q == FHC_RSTROBE);
      pins.width_sel <= cur_q.wide;
      pins.addr <= pin_addr(cur_q);
      dq_out <= cur_q.wdata;
      dq_oe[0] <= in_cycle && cur_q.write;
      dq_oe[1] <= in_cycle && cur_q.write && cur_q.wide;
    end
  end

  // ------------------------------------------------------------
  // Read capture and status
  // ------------------------------------------------------------
  // Sample at the end of the strobe; sync delay absorbed by read time
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rsp_valid <= 1'b0;
      rsp_data <= '0;
    end
    else
    begin
      rsp_valid <= (state_q == FHC_RSTROBE) && (cnt_q == '0);
      if ((state_q == FHC_RSTROBE) && (cnt_q == '0))
        rsp_data <= cur_q.wide ? dq_s
                    : {{BYTE_W{1'b0}}, dq_s[BYTE_W-1:0]};
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sts_prev_q <= 1'b1;
      busy_level <= 1'b0;
      done_pulse <= 1'b0;
    end
    else
    begin
      sts_prev_q <= sts_s;
      busy_level <= !sts_s && pins.reset_powerdown_n;
      done_pulse <= !sts_s && sts_prev_q;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_no_write_pd: assert property (@(posedge mclk) disable iff (!rst_n)
    !pins.reset_powerdown_n |-> pins.we_n)
    else $error("write strobe during powerdown");
  a_oe_we_excl: assert property (@(posedge mclk) disable iff (!rst_n)
    !(pins.oe_n == 1'b0 && pins.we_n == 1'b0))
    else $error("oe and we both low");
  a_cs_together: assert property (@(posedge mclk) disable iff (!rst_n)
    pins.cs_n == CS_IDLE || pins.cs_n == CS_ACTIVE)
    else $error("selects split");
  a_we_needs_cs: assert property (@(posedge mclk) disable iff (!rst_n)
    !pins.we_n |-> pins.cs_n == CS_ACTIVE && dq_oe[0])
    else $error("strobe without select or data");
  a_addr_stable: assert property (@(posedge mclk) disable iff (!rst_n)
    (!pins.we_n && !$past(pins.we_n)) |-> $stable(pins.addr))
    else $error("address moved under strobe");
  a_upper_x8: assert property (@(posedge mclk) disable iff (!rst_n)
    !pins.width_sel |-> !dq_oe[1])
    else $error("upper lane driven in x8");
  a_a0_x16: assert property (@(posedge mclk) disable iff (!rst_n)
    pins.width_sel && !pins.cs_n[0] |-> !pins.addr[0])
    else $error("byte-half set in x16");
  a_no_bus_fight: assert property (@(posedge mclk) disable iff (!rst_n)
    !pins.oe_n |-> dq_oe == 2'h0)
    else $error("host drives during read");
  a_wake_gap: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(pins.reset_powerdown_n) |-> pins.we_n [*2])
    else $error("write too soon after wake");
  c_write: cover property (@(posedge mclk) $rose(pins.we_n));
  c_read: cover property (@(posedge mclk) rsp_valid);
  c_busy: cover property (@(posedge mclk) $rose(busy_level));
endmodule : fhc_host

/* inc/fhc_pkg.sv */
package fhc_pkg;
  // ------------------------------------------------------------
  // Pin timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int T_STROBE_NS = 70;
  localparam int T_READ_NS = 150;
  localparam int T_SETUP_NS = 10;
  localparam int T_WAKE_NS = 30000;
  localparam int STROBE_CYC = (T_STROBE_NS * 1000 + CLK_PERIOD_PS - 1)
                              / CLK_PERIOD_PS;
  localparam int READ_CYC = (T_READ_NS * 1000 + CLK_PERIOD_PS - 1)
                            / CLK_PERIOD_PS;
  localparam int SETUP_CYC = (T_SETUP_NS * 1000 + CLK_PERIOD_PS - 1)
                             / CLK_PERIOD_PS;
  localparam int WAKE_CYC = (T_WAKE_NS * 1000 + CLK_PERIOD_PS - 1)
                            / CLK_PERIOD_PS;
  // ------------------------------------------------------------
  // Widths and fields
  // ------------------------------------------------------------
  localparam int ADDR_W = 23;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int READY_BIT = 7;
  localparam int CNT_W = 16;
  localparam logic [2:0] CS_IDLE = 3'h7;
  localparam logic [2:0] CS_ACTIVE = 3'h0;

  typedef enum logic [2:0]
  {
    FHC_RESET = 3'b000,
    FHC_WAKE = 3'b001,
    FHC_IDLE = 3'b010,
    FHC_WSETUP = 3'b011,
    FHC_WSTROBE = 3'b100,
    FHC_RSTROBE = 3'b101,
    FHC_HOLD = 3'b110
  } fhc_state_t;

  typedef struct packed
  {
    logic [2:0] cs_n;
    logic oe_n;
    logic we_n;
    logic width_sel;
    logic reset_powerdown_n;
    logic [ADDR_W-1:0] addr;
  } fhc_pins_t;

  typedef struct packed
  {
    logic write;
    logic wide;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } fhc_req_t;
endpackage : fhc_pkg

/* src/fhc_sync.sv */
`timescale 1ns/1ps
module fhc_sync
  import fhc_pkg::*;
#(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= RST_VAL;
      q <= RST_VAL;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : fhc_sync

/* bench/fhc_dev_model.sv */
`timescale 1ns/1ps
module fhc_dev_model
  import fhc_pkg::*;
(
  input wire fhc_pins_t pins,
  input wire logic [DATA_W-1:0] dq_out,
  input wire logic [1:0] dq_oe,
  input wire logic supply_below_protect,
  output logic [DATA_W-1:0] dq_in,
  output logic automation_status_out
);
  // ----------------------------------------
  // Array, selection, busy time
  // ----------------------------------------
  logic [7:0] mem [0:15];
  logic [ADDR_W-1:0] wa;
  logic [15:0] rd, dm, dv, hm, flt;
  logic busy;
  logic sel;
  logic oen;
  // Released lines change every cycle, never hold
  initial
  begin
    flt = 16'h5A5A;
    forever #5 flt = ~flt;
  end
  assign sel = pins.cs_n == CS_ACTIVE && pins.reset_powerdown_n;
  assign oen = sel && !pins.oe_n;
  assign rd = pins.width_sel
    ? {mem[{pins.addr[3:1], 1'b1}], mem[{pins.addr[3:1], 1'b0}]}
    : {8'h00, mem[pins.addr[3:0]]};
  // One process owns array and busy; powerdown cuts busy short
  // No lock bits kept, so every block takes writes as under override
  initial
  begin
    busy = 1'b0;
    wa = '0;
    for (int i = 0; i < 16; i++)
      mem[i] = 8'h00;
    forever
    begin
      @(posedge pins.we_n);
      if (sel && !busy && !supply_below_protect)
      begin
        wa = pins.addr;
        if (pins.width_sel)
          {mem[{wa[3:1], 1'b1}], mem[{wa[3:1], 1'b0}]} = dq_in;
        else
          mem[wa[3:0]] = dq_in[7:0];
        busy = 1'b1;
        for (int t = 0; t < 60 && pins.reset_powerdown_n; t++)
          #5;
        busy = 1'b0;
      end
    end
  end
  assign automation_status_out = !busy;
  assign dm = {{8{oen && !busy && pins.width_sel}}, oen,
    {7{oen && !busy}}};
  assign dv = busy ? 16'h0000 : rd;
  assign hm = {{8{dq_oe[1]}}, {8{dq_oe[0]}}};
  assign dq_in = (hm & dq_out) | (~hm & dm & dv) | (~hm & ~dm & flt);
endmodule : fhc_dev_model

/* bench/test_fhc_host.sv */
`timescale 1ns/1ps
module test_fhc_host;
  import fhc_pkg::*;
  logic mclk, rst_n, req_valid, req_ready, powerdown_req, rsp_valid;
  logic busy_level, done_pulse, sts, supply_low;
  fhc_req_t req;
  fhc_pins_t pins;
  logic [DATA_W-1:0] rsp_data, dq_out, dq_in, q;
  logic [1:0] dq_oe;
  int n_mismatch = 0;
  int check_count = 0;
  fhc_host #(.WAKE_CYCLES(4)) fhc_host_inst (.mclk(mclk), .rst_n(rst_n),
    .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .powerdown_req(powerdown_req), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .busy_level(busy_level), .done_pulse(done_pulse),
    .pins(pins), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in),
    .automation_status_out(sts));
  fhc_dev_model fhc_dev_model_inst (.pins(pins), .dq_out(dq_out),
    .dq_oe(dq_oe), .supply_below_protect(supply_low), .dq_in(dq_in),
    .automation_status_out(sts));
  initial
  begin
    mclk = 0;
    forever #2.5 mclk = ~mclk;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, g);
    check_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wait_for(ref logic s, input int lim);
    for (int n = 0; n < lim && s !== 1'b1; n++)
      @(negedge mclk);
  endtask : wait_for
  task automatic issue(input logic w, wd, input logic [22:0] a,
    input logic [15:0] d);
    @(negedge mclk);
    req = '{write: w, wide: wd, addr: a, wdata: d};
    req_valid = 1;
    wait_for(req_ready, 100);
    chk("req_ready", 1, req_ready);
    @(negedge mclk);
    req_valid = 0;
  endtask : issue
  task automatic rd(input logic wd, input logic [22:0] a);
    issue(0, wd, a, 16'h0000);
    wait_for(rsp_valid, 60);
    chk("rsp_valid", 1, rsp_valid);
    q = rsp_data;
  endtask : rd
  task automatic wr(input logic wd, input logic [22:0] a,
    input logic [15:0] d);
    int seen;
    int pulses;
    seen = 0;
    pulses = 0;
    issue(1, wd, a, d);
    for (int n = 0; n < 200; n++)
    begin
      @(negedge mclk);
      pulses += (done_pulse === 1'b1);
      if (busy_level === 1'b1)
        seen = 1;
      else if (seen == 1)
        break;
    end
    chk("busy_level", 1, seen);
    chk("done_pulse", 1, pulses);
  endtask : wr
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_word;
    wr(1, 23'h000005, 16'hBEEF);
    rd(1, 23'h000004);
    chk("word", 16'hBEEF, q);
    rd(0, 23'h000005);
    chk("hi_byte", 16'h00BE, q);
  endtask : t_word
  task automatic t_byte;
    wr(0, 23'h400009, 16'h00AA);
    chk("waddr", 32'h400009, fhc_dev_model_inst.wa);
    wr(0, 23'h000008, 16'h0055);
    rd(1, 23'h000008);
    chk("bytes", 16'hAA55, q);
  endtask : t_byte
  task automatic t_prot;
    supply_low = 1;
    issue(1, 0, 23'h000009, 16'h0011);
    repeat (40) @(negedge mclk);
    chk("busy_refused", 0, busy_level);
    supply_low = 0;
    rd(0, 23'h000009);
    chk("protected", 16'h00AA, q);
  endtask : t_prot
  task automatic t_pd;
    issue(1, 1, 23'h000002, 16'h1234);
    wait_for(busy_level, 100);
    rd(1, 23'h000008);
    chk("ready_bit", 0, q[READY_BIT]);
    powerdown_req = 1;
    repeat (4) @(negedge mclk);
    chk("rp_pin", 0, pins.reset_powerdown_n);
    chk("req_ready", 0, req_ready);
    chk("busy_clr", 0, busy_level);
    powerdown_req = 0;
    rd(1, 23'h000002);
    chk("array", 16'h1234, q);
  endtask : t_pd
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  initial
  begin
    #100000;
    n_mismatch++;
    wrap_up();
  end
  initial
  begin
    rst_n = 0;
    req_valid = 0;
    req = '0;
    powerdown_req = 0;
    supply_low = 0;
    repeat (10) @(posedge mclk);
    @(negedge mclk);
    rst_n = 1;
    t_word();
    t_byte();
    t_prot();
    t_pd();
    wrap_up();
  end
endmodule : test_fhc_host
